// file: hw/pulse_shaper_defs.vh
// Shared constants of the Gaussian transmit pulse shaper.
`ifndef PULSE_SHAPER_DEFS_VH
`define PULSE_SHAPER_DEFS_VH

// ****************************************************************
// Clock choice encodings, {clock_choice_b, clock_choice_a}
// ****************************************************************
`define RATE_9X            2'b00
`define RATE_12X           2'b01
`define RATE_16X           2'b10
`define RATE_16X_ALT       2'b11

// ****************************************************************
// Table steps per bit period after the optional divide by two
// ****************************************************************
`define STEPS_9X           4'd9
`define STEPS_12X          4'd6
`define STEPS_16X          4'd8

// ****************************************************************
// Half-bit sample offsets, in table steps
// ****************************************************************
`define HALF_9X            4'd4
`define HALF_12X           4'd3
`define HALF_16X           4'd4

// ****************************************************************
// Side-lobe weight per table step, chosen so the tails stay near 30 codes
// ****************************************************************
`define WEIGHT_9X          4'd4
`define WEIGHT_12X         4'd6
`define WEIGHT_16X         4'd4

// ****************************************************************
// Pulse table levels and history presets
// ****************************************************************
`define DAC_MID            8'h80
`define MAIN_LOBE          9'h040
`define HIST_PRESET_LOW    3'b010
`define HIST_PRESET_HIGH   3'b101

// ****************************************************************
// Output buffer geometry
// ****************************************************************
`define FIFO_DEPTH         16
`define FIFO_AW            4

`endif

// file: hw/sample_fifo.v
// Synchronous valid/ready FIFO that carries DAC codes toward the converter.
`timescale 1ns/1ns

module sample_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset.
   input  wire             i_core_clk,
   input  wire             i_arst_n,
   // Filling side.
   input  wire             i_in_valid,
   input  wire [WIDTH-1:0] i_in_data,
   output wire             o_in_ready,
   // Draining side.
   output wire             o_out_valid,
   output wire [WIDTH-1:0] o_out_data,
   input  wire             i_out_ready
);

   reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             push;
   wire             pop;

   assign o_in_ready  = (count_r != DEPTH[AW:0]);
   assign o_out_valid = (count_r != {(AW+1){1'b0}});
   assign o_out_data  = mem_r[rd_ptr_r];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
         always @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               mem_r[g] <= {WIDTH{1'b0}};
            end else if (push && (wr_ptr_r == g[AW-1:0])) begin
               mem_r[g] <= i_in_data;
            end
         end
      end
   endgenerate

   // Pointers wrap naturally, so DEPTH must be a power of two.
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// file: hw/gaussian_tx_pulse_shaper.v
// Gaussian transmit pulse shaper: bit sync, three-bit history, pulse table, output buffer.
`timescale 1ns/1ns
`include "pulse_shaper_defs.vh"

module gaussian_tx_pulse_shaper #(
   parameter FIFO_WIDTH = 8,
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW    = `FIFO_AW
) (
   // Clock and reset.
   input  wire       i_core_clk,
   input  wire       i_arst_n,
   // Burst controller side.
   input  wire       i_tx_data,
   input  wire       i_transmit_sleep,
   input  wire       i_clock_choice_a,
   input  wire       i_clock_choice_b,
   // Converter side.
   output wire [7:0] o_dac_code,
   output wire       o_dac_valid,
   input  wire       i_dac_ready
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam ST_SLEEP = 2'd0;
   localparam ST_WAIT  = 2'd1;
   localparam ST_RUN   = 2'd2;

   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg        tx_prev_r;
   reg        div_r;
   reg  [3:0] phase_r;
   reg  [3:0] phase_nxt;
   reg  [2:0] hist_r;
   reg  [2:0] hist_nxt;
   reg  [7:0] word_r;
   reg        word_valid_r;
   reg  [7:0] dac_code_r;
   reg        dac_valid_r;

   reg  [3:0] steps;
   reg  [3:0] half;
   reg  [3:0] weight;
   reg        div_en;
   reg  [3:0] out_phase;
   reg  [7:0] w_old;
   reg  [7:0] w_new;
   reg  [8:0] acc;
   reg  [7:0] table_code;

   wire       tick;
   wire       advance;
   wire       data_edge;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire       fifo_pop;

   // ****************************************************************
   // Clock choice decode
   // ****************************************************************
   always @* begin
      case ({i_clock_choice_b, i_clock_choice_a})
         `RATE_9X: begin
            div_en = 1'b0;
            steps  = `STEPS_9X;
            half   = `HALF_9X;
            weight = `WEIGHT_9X;
         end
         `RATE_12X: begin
            div_en = 1'b1;
            steps  = `STEPS_12X;
            half   = `HALF_12X;
            weight = `WEIGHT_12X;
         end
         default: begin
            div_en = 1'b1;
            steps  = `STEPS_16X;
            half   = `HALF_16X;
            weight = `WEIGHT_16X;
         end
      endcase
   end

   // The divider free-runs so the table rate never depends on burst state.
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_r <= 1'b0;
      end else begin
         div_r <= ~div_r;
      end
   end

   assign tick      = ~div_en | div_r;
   // A full output buffer holds the table step, so the bit clock slips rather than drops codes.
   assign advance   = tick & (~word_valid_r | fifo_in_ready);
   assign data_edge = i_tx_data ^ tx_prev_r;

   // ****************************************************************
   // Burst sequencing, sampling counter and bit history
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      hist_nxt  = hist_r;
      case (state_r)
         ST_SLEEP: begin
            phase_nxt = 4'h0;
            hist_nxt  = i_tx_data ? `HIST_PRESET_HIGH : `HIST_PRESET_LOW;
            if (!i_transmit_sleep) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // The idle level is the opposite of the first bit, so its first edge marks a bit start.
            if (data_edge) begin
               state_nxt = ST_RUN;
               phase_nxt = 4'h0;
            end
         end
         ST_RUN: begin
            if (advance) begin
               if (phase_r >= steps - 4'd1) begin
                  phase_nxt = 4'h0;
               end else begin
                  phase_nxt = phase_r + 4'd1;
               end
               if (phase_r == half) begin
                  hist_nxt = {hist_r[1:0], i_tx_data};
               end
            end
         end
         default: begin
            state_nxt = ST_SLEEP;
         end
      endcase
      if (i_transmit_sleep) begin
         state_nxt = ST_SLEEP;
         phase_nxt = 4'h0;
         hist_nxt  = i_tx_data ? `HIST_PRESET_HIGH : `HIST_PRESET_LOW;
      end
   end

   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r   <= ST_SLEEP;
         phase_r   <= 4'h0;
         hist_r    <= `HIST_PRESET_LOW;
         tx_prev_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         phase_r   <= phase_nxt;
         hist_r    <= hist_nxt;
         tx_prev_r <= i_tx_data;
      end
   end

   // ****************************************************************
   // Pulse table
   // ****************************************************************
   // The main lobe follows the middle history bit; the tails of the older and newer bits
   // fade out and in across the period that starts at the sampling instant.
   always @* begin
      if (phase_r >= half) begin
         out_phase = phase_r - half;
      end else begin
         out_phase = phase_r + steps - half;
      end
      w_old = (steps - 4'd1 - out_phase) * weight;
      w_new = out_phase * weight;
      acc   = {1'b0, `DAC_MID};
      if (hist_r[1]) begin
         acc = acc + `MAIN_LOBE;
      end else begin
         acc = acc - `MAIN_LOBE;
      end
      if (hist_r[2]) begin
         acc = acc + {1'b0, w_old};
      end else begin
         acc = acc - {1'b0, w_old};
      end
      if (hist_r[0]) begin
         acc = acc + {1'b0, w_new};
      end else begin
         acc = acc - {1'b0, w_new};
      end
      if (state_r == ST_RUN) begin
         table_code = acc[7:0];
      end else begin
         table_code = `DAC_MID;
      end
   end

   // ****************************************************************
   // Output staging
   // ****************************************************************
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         word_r       <= `DAC_MID;
         word_valid_r <= 1'b0;
      end else if (advance) begin
         word_r       <= table_code;
         word_valid_r <= 1'b1;
      end else if (fifo_in_ready) begin
         word_valid_r <= 1'b0;
      end
   end

   sample_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (word_valid_r),
      .i_in_data   (word_r),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (fifo_out_valid),
      .o_out_data  (fifo_out_data),
      .i_out_ready (fifo_pop)
   );

   assign fifo_pop = fifo_out_valid & (~dac_valid_r | i_dac_ready);

   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dac_code_r  <= `DAC_MID;
         dac_valid_r <= 1'b0;
      end else if (fifo_pop) begin
         dac_code_r  <= fifo_out_data;
         dac_valid_r <= 1'b1;
      end else if (i_dac_ready) begin
         dac_valid_r <= 1'b0;
      end
   end

   assign o_dac_code  = dac_code_r;
   assign o_dac_valid = dac_valid_r;

endmodule

// file: verif/gaussian_tx_pulse_shaper_props.sv
// Concurrent checks on the pulse shaper ports.
`timescale 1ns/1ns

module gaussian_tx_pulse_shaper_props (
   // Clock and reset.
   input wire       i_core_clk,
   input wire       i_arst_n,
   // Controller side.
   input wire       i_tx_data,
   input wire       i_transmit_sleep,
   input wire       i_clock_choice_a,
   input wire       i_clock_choice_b,
   // Converter side.
   input wire [7:0] o_dac_code,
   input wire       o_dac_valid,
   input wire       i_dac_ready
);
   // Counters saturate at 24 ready cycles, enough to flush stage, buffer and output.
   reg       edge_seen_r;
   reg       tx_last_r;
   reg [4:0] sleep_cnt_r;
   reg [4:0] wait_cnt_r;
   reg [4:0] run_cnt_r;
   always @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         edge_seen_r <= 1'b0;
         tx_last_r   <= 1'b0;
         sleep_cnt_r <= 5'h00;
         wait_cnt_r  <= 5'h00;
         run_cnt_r   <= 5'h00;
      end else begin
         tx_last_r   <= i_tx_data;
         edge_seen_r <= !i_transmit_sleep && (edge_seen_r || (i_tx_data != tx_last_r));
         sleep_cnt_r <= (i_transmit_sleep && i_dac_ready) ? sleep_cnt_r + {4'h0, sleep_cnt_r != 5'h18} : 5'h00;
         wait_cnt_r  <= (!i_transmit_sleep && !edge_seen_r && i_dac_ready) ?
                        wait_cnt_r + {4'h0, wait_cnt_r != 5'h18} : 5'h00;
         run_cnt_r   <= (!i_transmit_sleep && edge_seen_r && i_dac_ready) ?
                        run_cnt_r + {4'h0, run_cnt_r != 5'h18} : 5'h00;
      end
   end
   sequence s_stalled;
      o_dac_valid && !i_dac_ready;
   endsequence
   sequence s_ready_run;
      i_dac_ready [*6];
   endsequence
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   a_reset_mid_code: assert property ($rose(i_arst_n) |-> o_dac_code == 8'h80 && !o_dac_valid)
      else $error("code not mid-band at reset release");
   a_valid_held: assert property (s_stalled |=> o_dac_valid)
      else $error("valid dropped before acceptance");
   a_code_held: assert property (s_stalled |=> $stable(o_dac_code))
      else $error("code changed before acceptance");
   a_sleep_mid_code: assert property (sleep_cnt_r == 5'h18 && o_dac_valid |-> o_dac_code == 8'h80)
      else $error("code not mid-band while asleep");
   a_wait_mid_code: assert property (wait_cnt_r == 5'h18 && !edge_seen_r && o_dac_valid |-> o_dac_code == 8'h80)
      else $error("code left mid-band before first edge");
   a_run_off_mid: assert property (run_cnt_r == 5'h18 && o_dac_valid |-> o_dac_code != 8'h80)
      else $error("no pulse output after first edge");
   a_codes_flow: assert property (s_ready_run |-> o_dac_valid || $past(o_dac_valid))
      else $error("code stream stopped");
   a_code_span: assert property (o_dac_valid |-> o_dac_code >= 8'h20 && o_dac_code <= 8'he0)
      else $error("code outside pulse span");
endmodule

bind gaussian_tx_pulse_shaper gaussian_tx_pulse_shaper_props u_props (
   .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_tx_data(i_tx_data),
   .i_transmit_sleep(i_transmit_sleep), .i_clock_choice_a(i_clock_choice_a),
   .i_clock_choice_b(i_clock_choice_b), .o_dac_code(o_dac_code), .o_dac_valid(o_dac_valid),
   .i_dac_ready(i_dac_ready)
);

// file: verif/burst_ctrl_model.sv
// Burst controller model that feeds serial bits and sleep to the pulse shaper.
`timescale 1ns/1ns

module burst_ctrl_model (
   // Clock.
   input  wire       i_core_clk,
   // Burst request.
   input  wire       i_start,
   input  wire       i_idle_level,
   input  wire [4:0] i_bit_clks,
   input  wire [3:0] i_nbits,
   // Serial side.
   output reg        o_tx_data,
   output reg        o_transmit_sleep,
   output reg        o_busy
);
   integer k;
   initial begin
      o_tx_data        = 1'b0;
      o_transmit_sleep = 1'b1;
      o_busy           = 1'b0;
      forever begin
         @(negedge i_core_clk);
         if (i_start) begin
            o_busy    <= 1'b1;
            o_tx_data <= ~i_idle_level;
            repeat (4) @(negedge i_core_clk);
            o_tx_data <= i_idle_level;
            repeat (8) @(negedge i_core_clk);
            o_transmit_sleep <= 1'b0;
            repeat (40) @(negedge i_core_clk);
            // Alternating bits start 40 clocks after sleep lifts, then three pad bits flush the history.
            for (k = 0; k < i_nbits + 3; k = k + 1) begin
               o_tx_data <= ~o_tx_data;
               repeat (i_bit_clks) @(negedge i_core_clk);
            end
            o_transmit_sleep <= 1'b1;
            repeat (8) @(negedge i_core_clk);
            o_busy <= 1'b0;
         end
      end
   end
endmodule

// file: verif/gaussian_tx_pulse_shaper_test.sv
// Self-checking bench for the Gaussian transmit pulse shaper.
`timescale 1ns/1ns

module gaussian_tx_pulse_shaper_test;
   reg        i_core_clk;
   reg        i_arst_n;
   reg        i_clock_choice_a;
   reg        i_clock_choice_b;
   reg        i_dac_ready;
   reg        start;
   reg        lvl_r;
   reg  [4:0] bclk_r;
   reg        rec;
   reg  [7:0] codes [0:511];
   integer    n_codes;
   integer    failures;
   integer    n_compared;
   wire       tx_data;
   wire       sleep;
   wire       busy;
   wire [7:0] o_dac_code;
   wire       o_dac_valid;

   gaussian_tx_pulse_shaper uut (
      .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_tx_data(tx_data), .i_transmit_sleep(sleep),
      .i_clock_choice_a(i_clock_choice_a), .i_clock_choice_b(i_clock_choice_b),
      .o_dac_code(o_dac_code), .o_dac_valid(o_dac_valid), .i_dac_ready(i_dac_ready));
   burst_ctrl_model ctrl (
      .i_core_clk(i_core_clk), .i_start(start), .i_idle_level(lvl_r), .i_bit_clks(bclk_r),
      .i_nbits(4'h6), .o_tx_data(tx_data), .o_transmit_sleep(sleep), .o_busy(busy));

   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      if (rec && o_dac_valid && i_dac_ready && n_codes < 512) begin
         codes[n_codes] <= o_dac_code;
         n_codes <= n_codes + 1;
      end
   end

   task final_report;
      begin
         $display("compared %0d, mismatches %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task check_true(input ok, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (ok !== 1'b1) begin
            failures = failures + 1;
            $display("[FAIL] %0t check failed near code %h", $time, got);
         end
      end
   endtask
   task check_code(input [7:0] got, input [7:0] exp);
      begin
         check_true(got === exp, got);
      end
   endtask
   task wait_busy(input want);
      integer t;
      begin
         t = 0;
         while (busy !== want && t < 3000) begin
            @(negedge i_core_clk);
            t = t + 1;
         end
         if (busy !== want) begin
            failures = failures + 1;
            $display("[FAIL] %0t burst model timed out", $time);
            final_report;
         end
      end
   endtask

   // The buffer fills while the converter stalls, then drains back to back.
   task stall_sleep;
      begin
         i_dac_ready = 1'b0;
         repeat (30) begin
            @(negedge i_core_clk);
            check_true(o_dac_valid === 1'b1, o_dac_code);
            check_code(o_dac_code, 8'h80);
         end
         n_codes = 0;
         rec = 1'b1;
         i_dac_ready = 1'b1;
         repeat (20) @(negedge i_core_clk);
         rec = 1'b0;
         check_true(n_codes >= 16, 8'h80);
      end
   endtask

   task run_burst(input [1:0] sel, input lvl, input [4:0] bclk, input integer steps, input integer w);
      integer   i;
      integer   run;
      integer   nruns;
      integer   e;
      reg [7:0] prev;
      begin
         {i_clock_choice_b, i_clock_choice_a} = sel;
         lvl_r = lvl;
         bclk_r = bclk;
         e = lvl ? 64 + (steps - 1) * w : 192 - (steps - 1) * w;
         n_codes = 0;
         rec = 1'b1;
         start <= 1'b1;
         wait_busy(1'b1);
         start <= 1'b0;
         wait_busy(1'b0);
         // At 9x the buffer stays nearly full after a stall, so the burst tail needs time to drain out.
         repeat (24) @(negedge i_core_clk);
         rec = 1'b0;
         i = 0;
         while (i < n_codes && codes[i] === 8'h80)
            i = i + 1;
         check_true(i >= 20, codes[i]);
         check_code(codes[i], e[7:0]);
         prev = codes[i];
         run = 0;
         nruns = 0;
         while (i < n_codes && codes[i] !== 8'h80) begin
            if (codes[i] !== prev) begin
               if (nruns > 0)
                  check_true(run == steps, prev);
               else
                  check_true(run == steps / 2 + 1, prev);
               check_code(codes[i], ~prev + 8'h01);
               nruns = nruns + 1;
               run = 0;
               prev = codes[i];
            end
            run = run + 1;
            i = i + 1;
         end
         check_true(nruns >= 6, prev);
         check_code(codes[n_codes - 1], 8'h80);
      end
   endtask

   initial begin
      i_arst_n = 1'b0;
      i_dac_ready = 1'b1;
      {i_clock_choice_b, i_clock_choice_a} = 2'b00;
      start = 1'b0;
      lvl_r = 1'b0;
      bclk_r = 5'h09;
      rec = 1'b0;
      n_codes = 0;
      failures = 0;
      n_compared = 0;
      repeat (5) @(negedge i_core_clk);
      i_arst_n = 1'b1;
      repeat (40) @(negedge i_core_clk);
      stall_sleep;
      run_burst(2'b00, 1'b0, 5'h09, 9, 4);
      run_burst(2'b01, 1'b1, 5'h0c, 6, 6);
      run_burst(2'b10, 1'b0, 5'h10, 8, 4);
      run_burst(2'b11, 1'b1, 5'h10, 8, 4);
      final_report;
   end
endmodule
